/* verilog/homing_pkg.sv */
// constants, register map and types of the homing sequencer
package homing_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned RATED_RPM  = 3000;

  // register byte offsets
  localparam logic [7:0] A_METHOD = 8'h00;
  localparam logic [7:0] A_RAMP   = 8'h04;
  localparam logic [7:0] A_FAST   = 8'h08;
  localparam logic [7:0] A_SLOW   = 8'h0C;
  localparam logic [7:0] A_OFFSET = 8'h10;
  localparam logic [7:0] A_WINDOW = 8'h14;
  localparam logic [7:0] A_HOLD   = 8'h18;
  localparam logic [7:0] A_LIMSEL = 8'h1C;
  localparam logic [7:0] A_CFG    = 8'h20;
  localparam logic [7:0] A_DINMAP = 8'h24;
  localparam logic [7:0] A_DOUMAP = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h2C;
  localparam logic [7:0] A_CTRL   = 8'h30;

  // reset values
  localparam logic [15:0] METHOD_RST = 16'h0000;
  localparam logic [15:0] RAMP_RST   = 16'h01F4;
  localparam logic [15:0] FAST_RST   = 16'h01F4;
  localparam logic [15:0] SLOW_RST   = 16'h0064;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [15:0] WINDOW_RST = 16'h0005;
  localparam logic [15:0] HOLD_RST   = 16'h000A;
  localparam logic [15:0] LIMSEL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [31:0] DINMAP_RST = 32'h2C2B_221A;
  localparam logic [15:0] DOUMAP_RST = 16'h000F;

  // fields and limits
  localparam logic [15:0] RANGE_MASK  = 16'h7FFF;
  localparam logic [15:0] METHOD_MAX  = 16'h0063;
  localparam logic [15:0] LIM_FAULT   = 16'h0001;
  localparam int unsigned CFG_SETPOS  = 9;
  localparam int unsigned CTRL_CLRFLT = 0;
  localparam int unsigned ST_DONE     = 0;
  localparam int unsigned ST_FAULT    = 1;
  localparam int unsigned ST_BUSY     = 2;
  localparam int unsigned ST_HOMED    = 3;
  localparam int unsigned ST_STATE    = 4;
  localparam int unsigned ST_HOME     = 8;
  localparam int unsigned ST_PLIM     = 9;
  localparam int unsigned ST_NLIM     = 10;

  // input and output function codes
  localparam logic [7:0] FN_TRIG = 8'h1A;
  localparam logic [7:0] FN_HOME = 8'h22;
  localparam logic [7:0] FN_PLIM = 8'h2B;
  localparam logic [7:0] FN_NLIM = 8'h2C;
  localparam logic [7:0] FN_DONE = 8'h0F;

  // method codes
  localparam logic [15:0] M_NLIM_Z = 16'h0001;
  localparam logic [15:0] M_PLIM_Z = 16'h0002;
  localparam logic [15:0] M_NLIM   = 16'h0011;
  localparam logic [15:0] M_PLIM   = 16'h0012;
  localparam logic [15:0] M_Z_REV  = 16'h0021;
  localparam logic [15:0] M_Z_FWD  = 16'h0022;
  localparam logic [15:0] M_HERE   = 16'h0023;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_FAST   = 3'b001,
    S_SLOW   = 3'b011,
    S_ZWAIT  = 3'b010,
    S_SETTLE = 3'b110,
    S_FAULT  = 3'b100
  } hstate_t;
endpackage : homing_pkg

/* verilog/homing_sig_if.sv */
// conditioned homing inputs passed between sequencer modules
`timescale 1ns/1ps
interface homing_sig_if;
  logic trig_rise;
  logic home;
  logic plim;
  logic nlim;
  logic z_rise;
  modport src (output trig_rise, output home, output plim, output nlim, output z_rise);
  modport dst (input trig_rise, input home, input plim, input nlim, input z_rise);
endinterface : homing_sig_if

/* verilog/homing_inputs.sv */
// pin synchronisers, filters and input function mapping
`timescale 1ns/1ps
module homing_inputs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  din_i,
  input  wire logic        z_i,
  input  wire logic [31:0] din_map_i,
  homing_sig_if.src        sig
);
  import homing_pkg::*;

  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] f_r;
  logic [4:0] fd_r;

  // or over all inputs assigned to one function
  function automatic logic pick(input logic [3:0] lv, input logic [31:0] map, input logic [7:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hit = hit | (lv[i] & (map[8*i +: 8] == fn));
    end
    return hit;
  endfunction : pick

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      f_r  <= 5'h00;
      fd_r <= 5'h00;
    end else if (ce_i) begin
      s1_r <= {z_i, din_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r  <= (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
      fd_r <= f_r;
    end
  end

  assign sig.trig_rise = pick(f_r[3:0], din_map_i, FN_TRIG) & ~pick(fd_r[3:0], din_map_i, FN_TRIG);
  assign sig.home      = pick(f_r[3:0], din_map_i, FN_HOME);
  assign sig.plim      = pick(f_r[3:0], din_map_i, FN_PLIM);
  assign sig.nlim      = pick(f_r[3:0], din_map_i, FN_NLIM);
  assign sig.z_rise    = f_r[4] & ~fd_r[4];
endmodule : homing_inputs

/* verilog/homing_settle.sv */
// origin window and standstill check held for the completion time
`timescale 1ns/1ps
module homing_settle (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        arm_i,
  input  wire logic [31:0] pos_i,
  input  wire logic [31:0] target_i,
  input  wire logic [15:0] window_i,
  input  wire logic [15:0] hold_ms_i,
  input  wire logic [15:0] spd_ref_i,
  output logic             ok_o
);
  import homing_pkg::*;

  localparam logic [14:0] PRE_LAST = 15'(CYC_PER_MS - 1);

  logic [14:0] pre_r;
  logic [15:0] ms_r;

  wire logic [32:0] diff_w = {pos_i[31], pos_i} - {target_i[31], target_i};
  wire logic [32:0] mag_w  = diff_w[32] ? (33'h0 - diff_w) : diff_w;
  wire logic        cond_w = arm_i & (mag_w <= {17'h0, window_i}) & (spd_ref_i == 16'h0000);
  wire logic        held_w = ms_r >= hold_ms_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= 15'h0000;
      ms_r  <= 16'h0000;
      ok_o  <= 1'b0;
    end else if (ce_i) begin
      ok_o <= cond_w & held_w;
      if (!cond_w) begin
        pre_r <= 15'h0000;
        ms_r  <= 16'h0000;
      end else if (!held_w) begin
        pre_r <= (pre_r == PRE_LAST) ? 15'h0000 : pre_r + 15'h0001;
        ms_r  <= (pre_r == PRE_LAST) ? ms_r + 16'h0001 : ms_r;
      end
    end
  end
endmodule : homing_settle

/* verilog/servo_homing_sequencer.sv */
// homing sequencer with wishbone register file
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module servo_homing_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic [3:0]  din_i,
  input  wire logic        z_index_i,
  input  wire logic        drive_enabled_i,
  input  wire logic [31:0] enc_pos_i,
  input  wire logic [15:0] position_speed_reference_i,
  output logic [1:0]       dout_o,
  output logic [15:0]      speed_o,
  output logic             dir_fwd_o,
  output logic             moving_o,
  output logic [31:0]      ramp_ms_o,
  output logic             pos_set_o,
  output logic [31:0]      pos_set_val_o,
  output logic             pos_move_o,
  output logic [31:0]      pos_target_o,
  output logic             fault_o,
  output logic             busy_o
);
  import homing_pkg::*;

  logic [15:0] homing_method_select_r;
  logic [15:0] homing_ramp_time_r;
  logic [15:0] homing_fast_speed_r;
  logic [15:0] homing_slow_speed_r;
  logic [31:0] homing_position_offset_r;
  logic [15:0] origin_window_r;
  logic [15:0] completion_hold_time_r;
  logic [15:0] limit_enable_select_r;
  logic [15:0] function_config_word_r;
  logic [31:0] din_map_r;
  logic [15:0] dout_map_r;
  hstate_t     st_r;
  hstate_t     st_nxt;
  logic        homed_r;
  logic        done_r;
  logic        settle_ok;
  logic        arm_w;
  logic [31:0] rd_nxt;

  homing_sig_if sig ();

  homing_inputs u_inputs (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .din_i     (din_i),
    .z_i       (z_index_i),
    .din_map_i (din_map_r),
    .sig       (sig)
  );

  homing_settle u_settle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .arm_i     (arm_w),
    .pos_i     (enc_pos_i),
    .target_i  (pos_target_o),
    .window_i  (origin_window_r),
    .hold_ms_i (completion_hold_time_r),
    .spd_ref_i (position_speed_reference_i),
    .ok_o      (settle_ok)
  );

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nv[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nv, input logic [3:0] sel);
    logic [31:0] res;
    res = merge({16'h0, old}, nv, sel);
    return res[15:0];
  endfunction : merge16

  // method codes this block can run
  function automatic logic supported(input logic [15:0] m);
    return (m == M_NLIM_Z) | (m == M_PLIM_Z) | (m == M_NLIM) | (m == M_PLIM) |
           (m == M_Z_REV) | (m == M_Z_FWD) | (m == M_HERE);
  endfunction : supported

  // bus decode
  wire logic        req_w    = cyc_i & stb_i & ~ack_o;
  wire logic        wr_w     = cyc_i & stb_i & we_i & ack_o; // lands at the acknowledged edge
  wire logic [31:0] wdat_w   = dat_i;
  wire logic        wr_meth  = wr_w & (adr_i == A_METHOD);
  wire logic        wr_ramp  = wr_w & (adr_i == A_RAMP);
  wire logic        wr_fast  = wr_w & (adr_i == A_FAST);
  wire logic        wr_slow  = wr_w & (adr_i == A_SLOW);
  wire logic        wr_off   = wr_w & (adr_i == A_OFFSET);
  wire logic        wr_win   = wr_w & (adr_i == A_WINDOW);
  wire logic        wr_hold  = wr_w & (adr_i == A_HOLD);
  wire logic        wr_lim   = wr_w & (adr_i == A_LIMSEL);
  wire logic        wr_cfg   = wr_w & (adr_i == A_CFG);
  wire logic        wr_dinm  = wr_w & (adr_i == A_DINMAP);
  wire logic        wr_doum  = wr_w & (adr_i == A_DOUMAP);
  wire logic        clr_flt  = wr_w & (adr_i == A_CTRL) & sel_i[0] & wdat_w[CTRL_CLRFLT];

  // method write takes effect only with the drive disabled and in range
  wire logic [15:0] meth_new = merge16(homing_method_select_r, wdat_w, sel_i);
  wire logic        meth_ok  = ~drive_enabled_i & (meth_new <= METHOD_MAX);

  // method decode
  wire logic [15:0] meth_w   = homing_method_select_r;
  wire logic        plim_m   = (meth_w == M_PLIM_Z) | (meth_w == M_PLIM);
  wire logic        use_z    = (meth_w == M_NLIM_Z) | (meth_w == M_PLIM_Z);
  wire logic        z_only   = (meth_w == M_Z_REV) | (meth_w == M_Z_FWD);
  wire logic        ref_w    = plim_m ? sig.plim : sig.nlim;
  wire logic        toward_w = plim_m;
  wire logic        lim_flt  = (limit_enable_select_r == LIM_FAULT) & (sig.plim | sig.nlim);
  wire logic        start_w  = sig.trig_rise & (st_r == S_IDLE) & supported(meth_w) & ~lim_flt;
  wire logic        set_pos  = function_config_word_r[CFG_SETPOS];
  wire logic        org_w    = ((st_r == S_SLOW) & ~ref_w & ~use_z) |
                               ((st_r == S_ZWAIT) & sig.z_rise) |
                               (start_w & (meth_w == M_HERE));
  wire logic [31:0] ramp_pr  = {16'h0, homing_fast_speed_r} * {16'h0, homing_ramp_time_r};
  wire logic [31:0] ramp_eff = ramp_pr / RATED_RPM;
  assign arm_w = homed_r & ~org_w;

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: begin
        if (start_w) begin
          if (meth_w == M_HERE) begin
            st_nxt = S_SETTLE;
          end else if (z_only) begin
            st_nxt = S_ZWAIT;
          end else if (ref_w) begin
            st_nxt = S_SLOW;
          end else begin
            st_nxt = S_FAST;
          end
        end
      end
      S_FAST: begin
        if (ref_w) begin
          st_nxt = S_SLOW;
        end
      end
      S_SLOW: begin
        if (!ref_w) begin
          st_nxt = use_z ? S_ZWAIT : S_SETTLE;
        end
      end
      S_ZWAIT: begin
        if (sig.z_rise) begin
          st_nxt = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (settle_ok) begin
          st_nxt = S_IDLE;
        end
      end
      S_FAULT: begin
        if (clr_flt) begin
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    if (lim_flt) begin
      st_nxt = S_FAULT;
    end
  end

  // motion command for the next state
  wire logic        fast_nx  = st_nxt == S_FAST;
  wire logic        slow_nx  = (st_nxt == S_SLOW) | (st_nxt == S_ZWAIT);
  wire logic [15:0] spd_nx   = fast_nx ? homing_fast_speed_r : (slow_nx ? homing_slow_speed_r : 16'h0000);
  wire logic        dir_nx   = z_only ? (meth_w == M_Z_FWD) : (fast_nx ? toward_w : ~toward_w);
  wire logic        done_nxt = homed_r & settle_ok & ~start_w;

  // read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (adr_i)
      A_METHOD: rd_nxt = {16'h0, homing_method_select_r};
      A_RAMP:   rd_nxt = {16'h0, homing_ramp_time_r};
      A_FAST:   rd_nxt = {16'h0, homing_fast_speed_r};
      A_SLOW:   rd_nxt = {16'h0, homing_slow_speed_r};
      A_OFFSET: rd_nxt = homing_position_offset_r;
      A_WINDOW: rd_nxt = {16'h0, origin_window_r};
      A_HOLD:   rd_nxt = {16'h0, completion_hold_time_r};
      A_LIMSEL: rd_nxt = {16'h0, limit_enable_select_r};
      A_CFG:    rd_nxt = {16'h0, function_config_word_r};
      A_DINMAP: rd_nxt = din_map_r;
      A_DOUMAP: rd_nxt = {16'h0, dout_map_r};
      A_STATUS: begin
        rd_nxt[ST_DONE]           = done_r;
        rd_nxt[ST_FAULT]          = fault_o;
        rd_nxt[ST_BUSY]           = busy_o;
        rd_nxt[ST_HOMED]          = homed_r;
        rd_nxt[ST_STATE +: 3]     = st_r;
        rd_nxt[ST_HOME]           = sig.home;
        rd_nxt[ST_PLIM]           = sig.plim;
        rd_nxt[ST_NLIM]           = sig.nlim;
      end
      default:  rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus slave answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req_w;
      dat_o <= (req_w & ~we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      homing_method_select_r   <= METHOD_RST;
      homing_ramp_time_r       <= RAMP_RST;
      homing_fast_speed_r      <= FAST_RST;
      homing_slow_speed_r      <= SLOW_RST;
      homing_position_offset_r <= OFFSET_RST;
      origin_window_r          <= WINDOW_RST;
      completion_hold_time_r   <= HOLD_RST;
      limit_enable_select_r    <= LIMSEL_RST;
      function_config_word_r   <= CFG_RST;
      din_map_r                <= DINMAP_RST;
      dout_map_r               <= DOUMAP_RST;
    end else if (ce_i) begin
      if (wr_meth & meth_ok) homing_method_select_r <= meth_new;
      if (wr_ramp) homing_ramp_time_r <= merge16(homing_ramp_time_r, wdat_w, sel_i) & RANGE_MASK;
      if (wr_fast) homing_fast_speed_r <= merge16(homing_fast_speed_r, wdat_w, sel_i) & RANGE_MASK;
      if (wr_slow) homing_slow_speed_r <= merge16(homing_slow_speed_r, wdat_w, sel_i) & RANGE_MASK;
      if (wr_off) homing_position_offset_r <= merge(homing_position_offset_r, wdat_w, sel_i);
      if (wr_win) origin_window_r <= merge16(origin_window_r, wdat_w, sel_i) & RANGE_MASK;
      if (wr_hold) completion_hold_time_r <= merge16(completion_hold_time_r, wdat_w, sel_i);
      if (wr_lim) limit_enable_select_r <= merge16(limit_enable_select_r, wdat_w, sel_i);
      if (wr_cfg) function_config_word_r <= merge16(function_config_word_r, wdat_w, sel_i);
      if (wr_dinm) din_map_r <= merge(din_map_r, wdat_w, sel_i);
      if (wr_doum) dout_map_r <= merge16(dout_map_r, wdat_w, sel_i);
    end
  end

  // sequencer state and homed flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= S_IDLE;
      homed_r <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (org_w) begin
        homed_r <= 1'b1;
      end else if (start_w | lim_flt) begin
        homed_r <= 1'b0;
      end
    end
  end

  // motion and position outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_o       <= 16'h0000;
      dir_fwd_o     <= 1'b0;
      moving_o      <= 1'b0;
      ramp_ms_o     <= 32'h0000_0000;
      pos_set_o     <= 1'b0;
      pos_set_val_o <= 32'h0000_0000;
      pos_move_o    <= 1'b0;
      pos_target_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      speed_o   <= spd_nx;
      dir_fwd_o <= dir_nx;
      moving_o  <= fast_nx | slow_nx;
      ramp_ms_o <= ramp_eff;
      pos_set_o  <= org_w;
      pos_move_o <= org_w & ~set_pos;
      if (org_w) begin
        pos_set_val_o <= set_pos ? homing_position_offset_r : 32'h0000_0000;
        pos_target_o  <= homing_position_offset_r;
      end
    end
  end

  // status outputs and done routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r  <= 1'b0;
      fault_o <= 1'b0;
      busy_o  <= 1'b0;
      dout_o  <= 2'b00;
    end else if (ce_i) begin
      done_r  <= done_nxt;
      fault_o <= st_nxt == S_FAULT;
      busy_o  <= (st_nxt != S_IDLE) & (st_nxt != S_FAULT);
      for (int i = 0; i < 2; i++) begin
        dout_o[i] <= done_nxt & (dout_map_r[8*i +: 8] == FN_DONE);
      end
    end
  end
endmodule : servo_homing_sequencer

/* tb/axis_model.sv */
// axis model: position, limit switches and index pulse
`timescale 1ns/1ps
module axis_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        moving_i,
  input  wire logic        fwd_i,
  input  wire logic [15:0] speed_i,
  input  wire logic        set_i,
  input  wire logic [31:0] set_val_i,
  input  wire logic        move_i,
  input  wire logic [31:0] target_i,
  output logic      [31:0] pos_o,
  output logic      [15:0] spd_ref_o,
  output logic             plim_o,
  output logic             nlim_o,
  output logic             z_o
);
  // one count a cycle while searching
  always @(posedge clk_i) begin
    if (rst_i) pos_o <= 32'h0;
    else if (move_i) pos_o <= target_i;
    else if (set_i) pos_o <= set_val_i;
    else if (moving_i) pos_o <= fwd_i ? pos_o + 32'h1 : pos_o - 32'h1;
  end
  assign spd_ref_o = moving_i ? speed_i : 16'h0;
  assign plim_o    = $signed(pos_o) > 2000;
  assign nlim_o    = $signed(pos_o) < -2000;
  assign z_o       = (($signed(pos_o) % 500 + 500) % 500) < 4;
endmodule : axis_model

/* tb/servo_homing_sequencer_sva.sv */
// checker of the homing sequencer ports
`timescale 1ns/1ps
module homing_seq_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [1:0]  dout_o,
  input wire logic [15:0] speed_o,
  input wire logic        moving_o,
  input wire logic        pos_set_o,
  input wire logic        pos_move_o,
  input wire logic        fault_o,
  input wire logic        busy_o,
  input wire logic [15:0] position_speed_reference_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero");
  AST_FAULT_STOP: assert property (fault_o |-> !moving_o && speed_o == 16'h0)
    else $error("motion during fault");
  AST_IDLE_ZERO: assert property (!moving_o |-> speed_o == 16'h0)
    else $error("speed without search");
  AST_SET_PULSE: assert property (pos_set_o |=> !pos_set_o)
    else $error("origin pulse too long");
  AST_MOVE_WITH_SET: assert property (pos_move_o |-> pos_set_o)
    else $error("move pulse without origin");
  AST_DONE_STILL: assert property (dout_o[0] |-> $past(position_speed_reference_i, 2) == 16'h0)
    else $error("done while speed reference nonzero");
  AST_MOVE_BUSY: assert property (moving_o |-> busy_o)
    else $error("search without busy");
  AST_START_CLEAR: assert property ($rose(moving_o) |-> ##3 dout_o == 2'b00)
    else $error("done not cleared at start");
endmodule : homing_seq_sva
bind servo_homing_sequencer homing_seq_sva i_homing_seq_sva (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .dat_o,
  .ack_o, .dout_o, .speed_o, .moving_o, .pos_set_o, .pos_move_o, .fault_o, .busy_o, .position_speed_reference_i);

/* tb/tb.sv */
// testbench of the homing sequencer
`timescale 1ns/1ps
module tb;
  import homing_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, trig = 1'b0, drv_en = 1'b0;
  logic [7:0]  adr = 8'h00, lf = 8'h46;
  logic [31:0] dat = 32'h0, dat_o, ramp, psv, pt, pos;
  logic [15:0] spd, sref;
  logic [1:0]  dout;
  logic        ack_o, fwd, mov, pset, pmov, flt, busy, plim, nlim, z;
  logic [31:0] rd_q[$];
  logic [64:0] set_q[$];
  int          fail_count = 0, n_compared = 0;
  localparam logic [7:0]  A_T [10] = '{A_METHOD, A_RAMP, A_FAST, A_SLOW, A_OFFSET, A_WINDOW, A_HOLD, A_DINMAP,
    A_DOUMAP, 8'hFC};
  localparam logic [31:0] R_T [10] = '{{16'h0, METHOD_RST}, {16'h0, RAMP_RST}, {16'h0, FAST_RST}, {16'h0, SLOW_RST},
    OFFSET_RST, {16'h0, WINDOW_RST}, {16'h0, HOLD_RST}, DINMAP_RST, {16'h0, DOUMAP_RST}, 32'h0};
  localparam logic [15:0] M_T [7] = '{M_NLIM_Z, M_PLIM_Z, M_NLIM, M_PLIM, M_Z_REV, M_Z_FWD, M_HERE};
  localparam logic [6:0]  FWD_T = 7'b0101010;
  localparam logic [6:0]  FAST_T = 7'b0001111;
  initial forever #20 clk_i = ~clk_i;
  servo_homing_sequencer i_servo_homing_sequencer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .din_i({nlim, plim, 1'b0, trig}), .z_index_i(z), .drive_enabled_i(drv_en), .enc_pos_i(pos),
    .position_speed_reference_i(sref), .dout_o(dout), .speed_o(spd), .dir_fwd_o(fwd), .moving_o(mov),
    .ramp_ms_o(ramp), .pos_set_o(pset), .pos_set_val_o(psv), .pos_move_o(pmov), .pos_target_o(pt),
    .fault_o(flt), .busy_o(busy));
  axis_model i_axis_model (.clk_i(clk_i), .rst_i(rst_i), .moving_i(mov), .fwd_i(fwd), .speed_i(spd),
    .set_i(pset), .set_val_i(psv), .move_i(pmov), .target_i(pt), .pos_o(pos), .spd_ref_o(sref),
    .plim_o(plim), .nlim_o(nlim), .z_o(z));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_for(input int k);
    logic hit;
    for (int n = 0; n < 40000; n++) begin
      @(posedge clk_i);
      case (k)
        0: hit = mov === 1'b1;
        1: hit = dout[0] === 1'b1;
        2: hit = busy === 1'b0;
        default: hit = flt === 1'b1;
      endcase
      if (hit) return;
    end
    fail_count++;
    tally_and_finish();
  endtask : wait_for
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    if (!w) rd_q.push_back(e);
    for (int n = 0; n < 50 && ack_o !== 1'b1; n++) @(posedge clk_i);
    if (ack_o !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic pulse;
    @(posedge clk_i);
    trig <= 1'b1;
    repeat (6) @(posedge clk_i);
    trig <= 1'b0;
  endtask : pulse
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  // results are matched against the oldest note
  always @(posedge clk_i) begin
    logic [64:0] e;
    if (ack_o === 1'b1 && we === 1'b0 && rd_q.size() > 0) chk("read", rd_q.pop_front(), dat_o);
    if (pset === 1'b1) begin
      if (set_q.size() == 0) chk("set_extra", 32'h0, 32'h1);
      else begin
        e = set_q.pop_front();
        chk("set_val", e[63:32], psv);
        chk("move", {31'h0, e[64]}, {31'h0, pmov});
        chk("target", e[31:0], pt);
      end
    end
  end
  initial begin
    logic [31:0] off;
    do_reset();
    foreach (A_T[i]) wb(1'b0, A_T[i], 32'h0, R_T[i]);
    chk("ramp_ms", 32'h0000_0053, ramp);
    wb(1'b1, A_FAST, 32'h0000_FFFF, 32'h0);
    wb(1'b0, A_FAST, 32'h0, 32'h0000_7FFF);
    wb(1'b1, A_FAST, {16'h0, FAST_RST}, 32'h0);
    drv_en <= 1'b1;
    wb(1'b1, A_METHOD, 32'h1, 32'h0);
    wb(1'b0, A_METHOD, 32'h0, 32'h0);
    drv_en <= 1'b0;
    wb(1'b1, A_METHOD, 32'h0000_0064, 32'h0);
    wb(1'b0, A_METHOD, 32'h0, 32'h0);
    wb(1'b1, A_LIMSEL, 32'h2, 32'h0);
    wb(1'b1, A_HOLD, 32'h0, 32'h0);
    foreach (M_T[i]) begin
      lf = lfsr(lf);
      off = {24'h0, lf};
      wb(1'b1, A_METHOD, {16'h0, M_T[i]}, 32'h0);
      wb(1'b1, A_OFFSET, off, 32'h0);
      wb(1'b1, A_CFG, i[0] ? 32'h0000_0200 : 32'h0, 32'h0);
      set_q.push_back({~i[0], i[0] ? off : 32'h0, off});
      pulse();
      if (M_T[i] != M_HERE) begin
        wait_for(0);
        chk("dir", {31'h0, FWD_T[i]}, {31'h0, fwd});
        chk("speed", FAST_T[i] ? {16'h0, FAST_RST} : {16'h0, SLOW_RST}, {16'h0, spd});
        repeat (4) @(posedge clk_i);
        chk("done_start", 32'h0, {30'h0, dout});
      end
      wait_for(1);
      wait_for(2);
    end
    chk("pending", 32'h0, set_q.size());
    wb(1'b1, A_LIMSEL, {16'h0, LIM_FAULT}, 32'h0);
    wb(1'b1, A_METHOD, {16'h0, M_PLIM_Z}, 32'h0);
    pulse();
    wait_for(3);
    chk("busy", 32'h0, {31'h0, busy});
    wb(1'b1, A_CTRL, 32'h0000_0001, 32'h0);
    wb(1'b0, A_STATUS, 32'h0, 32'h0000_0242);
    do_reset();
    wb(1'b0, A_LIMSEL, 32'h0, {16'h0, LIMSEL_RST});
    chk("fault", 32'h0, {31'h0, flt});
    tally_and_finish();
  end
endmodule : tb
